// ### hw/msl_pkg.sv
// Shared constants and carrier types for the measurement sequencer block.
// Assumes a 200 MHz system clock and a register port fed by a serial engine.
package msl_pkg;

   // Clock rate and conversion times; cycle counts round down from typical times.
   localparam int unsigned CLK_MHZ     = 200;
   localparam int unsigned T_INT_NS    = 712000;
   localparam int unsigned T_EXT_NS    = 1510000;
   localparam int unsigned T_AIN_NS    = 712000;
   localparam int unsigned T_INT_CYC   = T_INT_NS * CLK_MHZ / 1000;
   localparam int unsigned T_EXT_CYC   = T_EXT_NS * CLK_MHZ / 1000;
   localparam int unsigned T_AIN_CYC   = T_AIN_NS * CLK_MHZ / 1000;
   localparam int unsigned CNT_W       = 19;

   // Channel codes, in storage order.
   localparam logic [3:0] CH_VDD  = 4'h0;
   localparam logic [3:0] CH_INT  = 4'h1;
   localparam logic [3:0] CH_EXT  = 4'h2;
   localparam logic [3:0] CH_AIN1 = 4'h3;
   localparam logic [3:0] CH_AIN2 = 4'h4;
   localparam logic [3:0] CH_AIN3 = 4'h5;
   localparam logic [3:0] CH_LAST = 4'ha;
   localparam int unsigned NCH    = 11;

   // Averaging: sixteen samples, result is the sum shifted down by four.
   localparam logic [3:0] AVG_LAST = 4'hf;

   // Register offsets.
   localparam logic [7:0] OFF_STAT_A   = 8'h00;
   localparam logic [7:0] OFF_STAT_B   = 8'h01;
   localparam logic [7:0] OFF_VDD_LSB  = 8'h03;
   localparam logic [7:0] OFF_MSB_BASE = 8'h06;
   localparam logic [7:0] OFF_MSB_LAST = 8'h10;
   localparam logic [7:0] OFF_CTRL_A   = 8'h18;
   localparam logic [7:0] OFF_CTRL_B   = 8'h19;
   localparam logic [7:0] OFF_MASK_A   = 8'h1d;
   localparam logic [7:0] OFF_MASK_B   = 8'h1e;
   localparam logic [7:0] OFF_LSB_BASE = 8'h20;
   localparam logic [7:0] OFF_LSB_LAST = 8'h2a;
   localparam logic [7:0] OFF_LIM_BASE = 8'h30;

   // Field positions.
   localparam int unsigned CA_MON    = 0;
   localparam int unsigned CA_EXT    = 1;
   localparam int unsigned CA_POL    = 3;
   localparam int unsigned CB_SINGLE = 4;
   localparam int unsigned CB_AVGOFF = 5;

   // Reset values.
   localparam logic [7:0] CTRL_A_RST  = 8'h00;
   localparam logic [7:0] CTRL_B_RST  = 8'h00;
   localparam logic [7:0] MASK_RST    = 8'h00;
   localparam logic [7:0] VLIM_HI_RST = 8'hff;
   localparam logic [7:0] VLIM_LO_RST = 8'h00;
   localparam logic [7:0] TLIM_HI_RST = 8'h7f;
   localparam logic [7:0] TLIM_LO_RST = 8'h80;
   localparam logic       INT_RST     = 1'b1;

   typedef enum logic [1:0] {
      MSL_IDLE = 2'b00,
      MSL_CONV = 2'b01,
      MSL_HOLD = 2'b11
   } msl_state_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } msl_req_t;

   typedef struct packed {
      msl_state_t           st;
      logic [CNT_W-1:0]     cnt;
      logic [3:0]           avg_n;
      logic [13:0]          acc;
      logic [3:0]           ch;
      logic [7:0]           ctrl_a;
      logic [7:0]           ctrl_b;
      logic [7:0]           mask_a;
      logic [7:0]           mask_b;
      logic [NCH-1:0][7:0]  lim_hi;
      logic [NCH-1:0][7:0]  lim_lo;
      logic [NCH-1:0]       flag;
      logic                 wr_en;
      logic [3:0]           wr_ch;
      logic [9:0]           wr_val;
      logic                 rd_p;
      logic [7:0]           rd_addr;
      logic [7:0]           rdata;
      logic                 rvalid;
      logic                 int_lvl;
      logic                 adc_rst;
   } msl_state_vec_t;

endpackage

// ### hw/msl_result_mem.sv
// Result store: one ten-bit word per channel, one write and one read port.
// Read data appear one clock after the address, from a register.
`timescale 1ns/1ps
`default_nettype none
module msl_result_mem (
   input  wire logic       sys_clk_i,
   input  wire logic       nrst_i,
   input  wire logic       wr_en_i,
   input  wire logic [3:0] wr_addr_i,
   input  wire logic [9:0] wr_data_i,
   input  wire logic [3:0] rd_addr_i,
   output logic      [9:0] rd_data_o
);

   typedef struct packed {
      logic [msl_pkg::NCH-1:0][9:0] mem;
      logic [9:0]                   rd;
   } msl_mem_t;

   msl_mem_t m_q;
   msl_mem_t m_d;

   always_comb
   begin
      m_d = m_q;
      if (!nrst_i)
      begin
         m_d = '0;
      end
      else
      begin
         if (rd_addr_i <= msl_pkg::CH_LAST)
            m_d.rd = m_q.mem[rd_addr_i];
         else
            m_d.rd = 10'h000;
         if (wr_en_i && wr_addr_i <= msl_pkg::CH_LAST)
            m_d.mem[wr_addr_i] = wr_data_i;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      m_q <= m_d;
   end

   assign rd_data_o = m_q.rd;

endmodule
`default_nettype wire

// ### hw/msl_sequencer.sv
// Measurement sequencer: channel selection, averaging, timing, limits, alarm.
// Assumes a serial engine that flags transactions and issues register requests,
// and an analog converter whose code on adc_data_i is valid at each sample point.
//
// Behaviour
// - High limit strict greater, low limit less-equal.
// - Out-of-limit input raises alarm against stored limits.
// - Limits are eight bits, results ten bits.
// - Violations of channels 1 to 8 flag in first status register, others in second, masked or not.
// - Alarm pin active while unmasked violation, polarity selectable.
// - Temperatures compared against own limits, flagged.
// - Single mode converts selected channel only.
// - Round robin: supply, internal, external/inputs, rest.
// - Single mode restarts same channel immediately.
// - Round robin loops forever, internal temperature each pass, external only when selected.
// - Results average sixteen samples by default.
// - Averaging on at reset, bit five disables.
// - Slow conversion times 712 us and 1.51 ms.
// - Serial transaction aborts conversion, restarts after.
// - Results readable as two byte registers.
// - Supply low bits at 03h, high at 06h.
// - Supply violations flag second status register.
// - Temperatures two's complement, quarter-degree steps.
// - Idle until monitor enable bit set.
// - Select zero is supply, one is internal.
`timescale 1ns/1ps
`default_nettype none
module msl_sequencer #(
   parameter int unsigned T_INT_CYC = msl_pkg::T_INT_CYC,
   parameter int unsigned T_EXT_CYC = msl_pkg::T_EXT_CYC,
   parameter int unsigned T_AIN_CYC = msl_pkg::T_AIN_CYC
) (
   input  wire logic              sys_clk_i,
   input  wire logic              nrst_i,
   input  wire msl_pkg::msl_req_t req_i,
   input  wire logic              xfer_active_i,
   input  wire logic [9:0]        adc_data_i,
   output logic      [7:0]        rdata_o,
   output logic                   rvalid_o,
   output logic      [3:0]        adc_chan_o,
   output logic                   adc_rst_o,
   output logic                   int_o
);

   msl_pkg::msl_state_vec_t s_q;
   msl_pkg::msl_state_vec_t s_d;

   logic                      mon;
   logic                      single;
   logic                      avgoff;
   logic                      pol;
   logic [3:0]                sel_c;
   logic                      is_temp;
   logic [msl_pkg::CNT_W-1:0] tconv;
   logic                      last;
   logic [13:0]               sx;
   logic [13:0]               sum;
   logic [9:0]                meas;
   logic [7:0]                msb;
   logic [7:0]                hi;
   logic [7:0]                lo;
   logic                      viol;
   logic [3:0]                nxt;
   logic [3:0]                mem_ra;
   logic [9:0]                mem_rd;

   assign mon    = s_q.ctrl_a[msl_pkg::CA_MON];
   assign pol    = s_q.ctrl_a[msl_pkg::CA_POL];
   assign single = s_q.ctrl_b[msl_pkg::CB_SINGLE];
   assign avgoff = s_q.ctrl_b[msl_pkg::CB_AVGOFF];
   assign sel_c  = (s_q.ctrl_b[3:0] > msl_pkg::CH_LAST) ? msl_pkg::CH_VDD : s_q.ctrl_b[3:0];
   assign is_temp = (s_q.ch == msl_pkg::CH_INT) || (s_q.ch == msl_pkg::CH_EXT);

   always_comb
   begin
      case (s_q.ch)
         msl_pkg::CH_INT: tconv = msl_pkg::CNT_W'(T_INT_CYC - 1);
         msl_pkg::CH_EXT: tconv = msl_pkg::CNT_W'(T_EXT_CYC - 1);
         default:         tconv = msl_pkg::CNT_W'(T_AIN_CYC - 1);
      endcase
   end
   assign last = (s_q.cnt == tconv);

   assign sx   = is_temp ? {{4{adc_data_i[9]}}, adc_data_i} : {4'h0, adc_data_i};
   assign sum  = s_q.acc + sx;
   assign meas = avgoff ? adc_data_i : sum[13:4];

   assign msb = meas[9:2];
   assign hi  = s_q.lim_hi[s_q.ch];
   assign lo  = s_q.lim_lo[s_q.ch];
   assign viol = is_temp ? (($signed(msb) > $signed(hi)) || ($signed(msb) <= $signed(lo)))
                         : ((msb > hi) || (msb <= lo));

   always_comb
   begin
      if (single)
         nxt = sel_c;
      else
      begin
         case (s_q.ch)
            msl_pkg::CH_INT:  nxt = s_q.ctrl_a[msl_pkg::CA_EXT] ? msl_pkg::CH_EXT
                                                                 : msl_pkg::CH_AIN1;
            msl_pkg::CH_EXT:  nxt = msl_pkg::CH_AIN3;
            msl_pkg::CH_LAST: nxt = msl_pkg::CH_VDD;
            default:          nxt = 4'(s_q.ch + 4'h1);
         endcase
      end
   end

   always_comb
   begin
      if (req_i.addr == msl_pkg::OFF_VDD_LSB)
         mem_ra = msl_pkg::CH_VDD;
      else if (req_i.addr >= msl_pkg::OFF_MSB_BASE && req_i.addr <= msl_pkg::OFF_MSB_LAST)
         mem_ra = 4'(req_i.addr - msl_pkg::OFF_MSB_BASE);
      else if (req_i.addr >= msl_pkg::OFF_LSB_BASE && req_i.addr <= msl_pkg::OFF_LSB_LAST)
         mem_ra = 4'(req_i.addr - msl_pkg::OFF_LSB_BASE);
      else
         mem_ra = 4'h0;
   end

   msl_result_mem u_mem (
      .sys_clk_i (sys_clk_i),
      .nrst_i    (nrst_i),
      .wr_en_i   (s_d.wr_en),
      .wr_addr_i (s_d.wr_ch),
      .wr_data_i (s_d.wr_val),
      .rd_addr_i (mem_ra),
      .rd_data_o (mem_rd)
   );

   always_comb
   begin
      s_d = s_q;
      s_d.wr_en  = 1'b0;
      s_d.rvalid = 1'b0;
      s_d.rd_p   = 1'b0;
      if (!nrst_i)
      begin
         s_d = '0;
         s_d.st      = msl_pkg::MSL_IDLE;
         s_d.ctrl_a  = msl_pkg::CTRL_A_RST;
         s_d.ctrl_b  = msl_pkg::CTRL_B_RST;
         s_d.mask_a  = msl_pkg::MASK_RST;
         s_d.mask_b  = msl_pkg::MASK_RST;
         s_d.int_lvl = msl_pkg::INT_RST;
         s_d.adc_rst = 1'b1;
         for (int i = 0; i < msl_pkg::NCH; i++)
         begin
            if (i == 1 || i == 2)
            begin
               s_d.lim_hi[i] = msl_pkg::TLIM_HI_RST;
               s_d.lim_lo[i] = msl_pkg::TLIM_LO_RST;
            end
            else
            begin
               s_d.lim_hi[i] = msl_pkg::VLIM_HI_RST;
               s_d.lim_lo[i] = msl_pkg::VLIM_LO_RST;
            end
         end
      end
      else
      begin
         if (req_i.wr)
         begin
            case (req_i.addr)
               msl_pkg::OFF_CTRL_A: s_d.ctrl_a = req_i.wdata;
               msl_pkg::OFF_CTRL_B: s_d.ctrl_b = req_i.wdata;
               msl_pkg::OFF_MASK_A: s_d.mask_a = req_i.wdata;
               msl_pkg::OFF_MASK_B: s_d.mask_b = req_i.wdata;
               default:             s_d.ctrl_a = s_q.ctrl_a;
            endcase
            for (int i = 0; i < msl_pkg::NCH; i++)
            begin
               if (req_i.addr == 8'(msl_pkg::OFF_LIM_BASE + 2 * i))
                  s_d.lim_hi[i] = req_i.wdata;
               if (req_i.addr == 8'(msl_pkg::OFF_LIM_BASE + 2 * i + 1))
                  s_d.lim_lo[i] = req_i.wdata;
            end
         end

         if (req_i.rd)
         begin
            s_d.rd_p    = 1'b1;
            s_d.rd_addr = req_i.addr;
         end
         if (s_q.rd_p)
         begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = 8'h00;
            case (s_q.rd_addr)
               msl_pkg::OFF_STAT_A: s_d.rdata = s_q.flag[8:1];
               msl_pkg::OFF_STAT_B: s_d.rdata = {5'h00, s_q.flag[10:9], s_q.flag[0]};
               msl_pkg::OFF_VDD_LSB: s_d.rdata = {6'h00, mem_rd[1:0]};
               msl_pkg::OFF_CTRL_A: s_d.rdata = s_q.ctrl_a;
               msl_pkg::OFF_CTRL_B: s_d.rdata = s_q.ctrl_b;
               msl_pkg::OFF_MASK_A: s_d.rdata = s_q.mask_a;
               msl_pkg::OFF_MASK_B: s_d.rdata = s_q.mask_b;
               default:             s_d.rdata = 8'h00;
            endcase
            if (s_q.rd_addr >= msl_pkg::OFF_MSB_BASE && s_q.rd_addr <= msl_pkg::OFF_MSB_LAST)
               s_d.rdata = mem_rd[9:2];
            if (s_q.rd_addr >= msl_pkg::OFF_LSB_BASE && s_q.rd_addr <= msl_pkg::OFF_LSB_LAST)
               s_d.rdata = {6'h00, mem_rd[1:0]};
            for (int i = 0; i < msl_pkg::NCH; i++)
            begin
               if (s_q.rd_addr == 8'(msl_pkg::OFF_LIM_BASE + 2 * i))
                  s_d.rdata = s_q.lim_hi[i];
               if (s_q.rd_addr == 8'(msl_pkg::OFF_LIM_BASE + 2 * i + 1))
                  s_d.rdata = s_q.lim_lo[i];
            end
         end

         case (s_q.st)
            msl_pkg::MSL_IDLE:
            begin
               s_d.adc_rst = 1'b1;
               if (mon && !xfer_active_i)
               begin
                  s_d.st      = msl_pkg::MSL_CONV;
                  s_d.ch      = single ? sel_c : msl_pkg::CH_VDD;
                  s_d.cnt     = '0;
                  s_d.acc     = '0;
                  s_d.avg_n   = '0;
                  s_d.adc_rst = 1'b0;
               end
            end
            msl_pkg::MSL_CONV:
            begin
               if (xfer_active_i || !mon)
               begin
                  s_d.st      = msl_pkg::MSL_HOLD;
                  s_d.adc_rst = 1'b1;
                  s_d.cnt     = '0;
                  s_d.acc     = '0;
                  s_d.avg_n   = '0;
               end
               else if (!last)
                  s_d.cnt = s_q.cnt + 1'b1;
               else
               begin
                  s_d.cnt = '0;
                  if (!avgoff && s_q.avg_n != msl_pkg::AVG_LAST)
                  begin
                     s_d.acc   = sum;
                     s_d.avg_n = s_q.avg_n + 4'h1;
                  end
                  else
                  begin
                     s_d.acc    = '0;
                     s_d.avg_n  = '0;
                     s_d.wr_en  = 1'b1;
                     s_d.wr_ch  = s_q.ch;
                     s_d.wr_val = meas;
                     s_d.flag[s_q.ch] = viol;
                     s_d.ch = nxt;
                  end
               end
            end
            msl_pkg::MSL_HOLD:
            begin
               s_d.adc_rst = 1'b1;
               if (!xfer_active_i)
               begin
                  s_d.st      = mon ? msl_pkg::MSL_CONV : msl_pkg::MSL_IDLE;
                  s_d.adc_rst = !mon;
               end
            end
            default:
            begin
               s_d.st      = msl_pkg::MSL_IDLE;
               s_d.adc_rst = 1'b1;
            end
         endcase

         if (s_d.ctrl_a[msl_pkg::CA_POL])
            s_d.int_lvl = |(s_d.flag & ~{s_d.mask_b[2:1], s_d.mask_a, s_d.mask_b[0]});
         else
            s_d.int_lvl = ~|(s_d.flag & ~{s_d.mask_b[2:1], s_d.mask_a, s_d.mask_b[0]});
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      s_q <= s_d;
   end

   assign rdata_o    = s_q.rdata;
   assign rvalid_o   = s_q.rvalid;
   assign adc_chan_o = s_q.ch;
   assign adc_rst_o  = s_q.adc_rst;
   assign int_o      = s_q.int_lvl;

   logic [10:0] unmasked;
   assign unmasked = s_q.flag & ~{s_q.mask_b[2:1], s_q.mask_a, s_q.mask_b[0]};

   property p_hi_flag;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      s_q.wr_en && s_q.wr_ch > msl_pkg::CH_EXT && s_q.wr_val[9:2] > $past(s_q.lim_hi[s_q.ch])
         |-> s_q.flag[s_q.wr_ch];
   endproperty
   a_hi_flag: assert property (p_hi_flag) else $error("high limit miss");

   property p_lo_flag;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      s_q.wr_en && s_q.wr_ch != msl_pkg::CH_INT && s_q.wr_ch != msl_pkg::CH_EXT
         && s_q.wr_val[9:2] > $past(s_q.lim_lo[s_q.ch])
         && s_q.wr_val[9:2] <= $past(s_q.lim_hi[s_q.ch]) |-> !s_q.flag[s_q.wr_ch];
   endproperty
   a_lo_flag: assert property (p_lo_flag) else $error("false limit flag");

   property p_int_pin;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      $past(nrst_i) |-> int_o == ((|unmasked) ~^ pol);
   endproperty
   a_int_pin: assert property (p_int_pin) else $error("alarm pin wrong");

   property p_single;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      s_q.wr_en && $past(single) && $past(s_q.ctrl_b[3:0]) <= msl_pkg::CH_LAST
         |-> s_q.ch == $past(s_q.ctrl_b[3:0]);
   endproperty
   a_single: assert property (p_single) else $error("single channel wrong");

   property p_rr_wrap;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      s_q.wr_en && !$past(single) && s_q.wr_ch == msl_pkg::CH_VDD |-> s_q.ch == msl_pkg::CH_INT;
   endproperty
   a_rr_wrap: assert property (p_rr_wrap) else $error("round robin order wrong");

   property p_abort;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      xfer_active_i |=> adc_rst_o && s_q.st != msl_pkg::MSL_CONV;
   endproperty
   a_abort: assert property (p_abort) else $error("conversion not aborted");

   property p_restart;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      s_q.st != msl_pkg::MSL_CONV && !xfer_active_i && mon ##1 !xfer_active_i
         |-> s_q.st == msl_pkg::MSL_CONV;
   endproperty
   a_restart: assert property (p_restart) else $error("no restart");

   property p_avg;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      s_q.wr_en |-> $past(s_q.avg_n) == msl_pkg::AVG_LAST || $past(avgoff);
   endproperty
   a_avg: assert property (p_avg) else $error("average count wrong");

   property p_ctime;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      s_q.wr_en && s_q.wr_ch == msl_pkg::CH_INT |-> $past(s_q.cnt) == msl_pkg::CNT_W'(T_INT_CYC - 1);
   endproperty
   a_ctime: assert property (p_ctime) else $error("conversion time wrong");

   c_flag:  cover property (@(posedge sys_clk_i) disable iff (!nrst_i) s_q.wr_en && s_q.flag[0]);
   c_abort: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
                            s_q.st == msl_pkg::MSL_HOLD ##1 s_q.st == msl_pkg::MSL_CONV);
   c_ext:   cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
                            s_q.wr_en && s_q.wr_ch == msl_pkg::CH_EXT);

endmodule
`default_nettype wire

// ### bench/msl_adc_model.sv
// Converter model: answers with a code for whichever channel the sequencer selects.
// Assumes the bench supplies the code table and holds it steady during a measurement.
`timescale 1ns/1ps
`default_nettype none
module msl_adc_model (
   input  wire logic       sys_clk_i,
   input  wire logic [3:0] chan_i,
   input  wire logic       adc_rst_i,
   input  wire logic [9:0] code_i [11],
   output logic      [9:0] adc_data_o
);
   logic [9:0] last_q;

   always_ff @(posedge sys_clk_i)
   begin
      if (!adc_rst_i)
      begin
         last_q <= code_i[chan_i];
      end
   end

   // A converter held in reset has no valid code; showing the inverse of the last one
   // stops a sequencer that samples it anyway from passing by luck.
   assign adc_data_o = adc_rst_i ? ~last_q : code_i[chan_i];
endmodule
`default_nettype wire

// ### bench/monitor_sequencer_limit_irq_tb.sv
// Testbench for the measurement sequencer: registers, channel order, timing, limits, alarm.
// Assumes the sequencer's register port and a converter model on its channel outputs.
`timescale 1ns/1ps
`default_nettype none
module monitor_sequencer_limit_irq_tb;
   localparam int unsigned TI = 8;
   localparam int unsigned TE = 12;
   localparam int unsigned TA = 6;
   logic              sys_clk_i = 1'b0;
   logic              nrst_i = 1'b0;
   msl_pkg::msl_req_t req = '0;
   logic              xfer = 1'b0;
   logic [9:0]        adc_data;
   logic [9:0]        codes [11];
   logic [7:0]        rdata;
   logic              rvalid;
   logic [3:0]        chan;
   logic              adc_rst;
   logic              int_o;
   logic [7:0]        rd_v;
   logic [31:0]       seed = 32'h11;
   int                failures = 0;
   int                samples_checked = 0;
   int                cyc = 0;
   int                d;
   logic [3:0]        prev;

   always #2.5 sys_clk_i = ~sys_clk_i;

   msl_sequencer #(.T_INT_CYC(TI), .T_EXT_CYC(TE), .T_AIN_CYC(TA)) dut (
      .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .req_i(req), .xfer_active_i(xfer),
      .adc_data_i(adc_data), .rdata_o(rdata), .rvalid_o(rvalid), .adc_chan_o(chan),
      .adc_rst_o(adc_rst), .int_o(int_o));

   msl_adc_model adc (.sys_clk_i(sys_clk_i), .chan_i(chan), .adc_rst_i(adc_rst),
      .code_i(codes), .adc_data_o(adc_data));

   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // Round-robin order after the supply channel, external sensor off.
   function automatic logic [3:0] f_rr(input int i);
      return (i == 0) ? 4'h1 : (i == 9) ? 4'h0 : 4'(i + 2);
   endfunction

   task automatic close_out();
      $display("counts: %0d checked, %0d failures", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      tick(1);
      req = '0;
      tick(1);
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      int n;
      req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      tick(1);
      req = '0;
      for (n = 0; n < 4 && rvalid !== 1'b1; n++) tick(1);
      chk(10'(rvalid), 10'h001);
      v = rdata;
      tick(1);
   endtask

   task automatic nxt(output int dur);
      dur = 0;
      prev = chan;
      while (chan === prev && dur < 400)
      begin
         tick(1);
         dur++;
      end
   endtask

   always @(posedge sys_clk_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         failures++;
         close_out();
      end
   end

   initial
   begin
      for (int i = 0; i < 11; i++)
      begin
         seed = xs(seed);
         codes[i] = seed[9:0] | 10'h100;
      end
      codes[1] = 10'h380;
      codes[2] = 10'h0c4;
      tick(3);
      nrst_i = 1'b1;
      chk(int_o, 1'b1);
      rd(8'h19, rd_v); chk(rd_v, 8'h00);
      rd(8'h30, rd_v); chk(rd_v, 8'hff);
      rd(8'h32, rd_v); chk(rd_v, 8'h7f);
      rd(8'h33, rd_v); chk(rd_v, 8'h80);
      tick(40);
      chk(adc_rst, 1'b1);
      $display("test reset and idle done");

      wr(8'h19, 8'h20);
      wr(8'h18, 8'h01);
      for (d = 0; d < 10 && adc_rst !== 1'b0; d++) tick(1);
      chk(chan, 4'h0);
      for (int i = 0; i < 10; i++)
      begin
         nxt(d);
         chk(10'(d), (prev == 4'h1) ? 10'(TI) : 10'(TA));
         chk(chan, f_rr(i));
      end
      // External sensor selected: it replaces the first two analog inputs in the loop.
      wr(8'h18, 8'h03);
      for (d = 0; d < 200 && chan !== 4'h1; d++) tick(1);
      nxt(d);
      chk(chan, 4'h2);
      nxt(d);
      chk(10'(d), 10'(TE));
      chk(chan, 4'h5);
      wr(8'h18, 8'h01);
      rd(8'h06, rd_v); chk(rd_v, codes[0][9:2]);
      rd(8'h03, rd_v); chk(rd_v, {6'h00, codes[0][1:0]});
      rd(8'h00, rd_v); chk(rd_v, 8'h00);
      chk(int_o, 1'b1);
      $display("test round robin done");

      wr(8'h37, codes[3][9:2]);
      wr(8'h32, 8'hdf);
      wr(8'h31, codes[0][9:2]);
      tick(150);
      rd(8'h00, rd_v); chk(rd_v, 8'h05);
      rd(8'h01, rd_v); chk(rd_v, 8'h01);
      chk(int_o, 1'b0);
      // Masking the alarms of the three violating channels, as a host should.
      wr(8'h1d, 8'h05);
      wr(8'h1e, 8'h01);
      tick(150);
      chk(int_o, 1'b1);
      rd(8'h00, rd_v); chk(rd_v, 8'h05);
      wr(8'h18, 8'h09);
      wr(8'h1e, 8'h00);
      tick(150);
      chk(int_o, 1'b1);
      $display("test limits done");

      seed = xs(seed);
      codes[5] = seed[9:0] | 10'h100;
      wr(8'h19, 8'h15);
      tick(16 * (TI + TA) + 40);
      chk(chan, 4'h5);
      rd(8'h0b, rd_v); chk(rd_v, codes[5][9:2]);
      rd(8'h25, rd_v); chk(rd_v, {6'h00, codes[5][1:0]});
      xfer = 1'b1;
      tick(2);
      chk(adc_rst, 1'b1);
      xfer = 1'b0;
      tick(2);
      chk(adc_rst, 1'b0);
      chk(chan, 4'h5);
      // Supply-only monitoring: single mode with a zero select.
      wr(8'h19, 8'h30);
      tick(20);
      chk(chan, 4'h0);
      wr(8'h06, 8'hff);
      rd(8'h06, rd_v); chk(rd_v, codes[0][9:2]);
      rd(8'h02, rd_v); chk(rd_v, 8'h00);
      wr(8'h18, 8'h08);
      tick(3);
      chk(adc_rst, 1'b1);
      $display("test single channel and abort done");
      close_out();
   end
endmodule
`default_nettype wire
